// file: core/dpcfg_top.sv
// Purpose: APB bank of the two datapath configuration registers and their decode
// Assumes: APB master synchronous to REF_CLK; soft reset level comes from elsewhere
// Notes: answers every transfer with one access cycle; bad address gives PSLVERR
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "dpcfg_regs.svh"

module dpcfg_top (
   input wire logic REF_CLK,
   input wire logic RESETN,
   input wire logic [11:0] PADDR,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   input wire logic LINK_DESER_IN_RESET,
   output logic PREADY,
   output logic [31:0] PRDATA,
   output logic PSLVERR,
   output dpcfg_pkg::dpcfg_cfg_t DPCFG_CFG
);
   import dpcfg_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   dpcfg_state_t state_r;
   dpcfg_state_t state_nxt;

   // ************************************************************
   // combinational signals
   // ************************************************************
   logic [4:0] dec_ratio;
   logic dec_valid;
   logic setup_phase;
   logic access_done;
   logic hit_interp;
   logic hit_feature;
   logic hit_status;
   logic aligned;
   logic [31:0] status_word;
   logic [7:0] feature_wr;
   logic write_ok;
   logic write_interp;
   logic write_feature;
   logic [7:0] interp_lane_nxt;
   logic [7:0] feature_nxt;
   logic [31:0] read_word;
   logic read_error;
   dpcfg_cfg_t cfg_nxt;

   // ************************************************************
   // address decode
   // ************************************************************
   assign aligned = (PADDR[1:0] == 2'h0);
   assign hit_interp = aligned && (PADDR[11:2] == `DPCFG_IDX_INTERP_LANE);
   assign hit_feature = aligned && (PADDR[11:2] == `DPCFG_IDX_FEATURE);
   assign hit_status = aligned && (PADDR[11:2] == `DPCFG_IDX_STATUS);
   assign setup_phase = PSEL && !PENABLE;
   assign access_done = PSEL && PENABLE && state_r.pready;

   // reserved bits never stored, so they read zero
   assign feature_wr = PWDATA[7:0] & `DPCFG_FEATURE_WMASK;

   // ************************************************************
   // write enables, one place for the commit condition
   // ************************************************************
   // an errored or unstrobed transfer never stores
   assign write_ok = access_done && PWRITE && PSTRB[0] && !state_r.pslverr;
   // no hardware check of soft reset: software owns that ordering
   assign write_interp = write_ok && hit_interp;
   assign write_feature = write_ok && hit_feature;
   assign interp_lane_nxt = write_interp ? PWDATA[7:0] : state_r.interp_lane;

   // ************************************************************
   // feature register next value, bit by bit
   // ************************************************************
   // reserved bits stay low: reset clears them and the mask keeps them clear
   for (genvar gb = 0; gb < $bits(feature_nxt); gb++) begin : g_feature_bit
      assign feature_nxt[gb] = write_feature ? feature_wr[gb] : state_r.feature[gb];
   end

   // ************************************************************
   // interpolation decode follows the code about to be stored
   // ************************************************************
   // decoding the next value keeps cfg in step with the field, with no loop
   dpcfg_interp_decode u_decode (
      .code(interp_lane_nxt[`DPCFG_INTERP_MSB:`DPCFG_INTERP_LSB]),
      .ratio(dec_ratio),
      .valid(dec_valid)
   );

   // ************************************************************
   // status view of the block's own state
   // ************************************************************
   // link state shown live: a level from outside, not a stored bit
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`DPCFG_ST_RATIO_MSB:`DPCFG_ST_RATIO_LSB] = state_r.cfg.interp_ratio;
      status_word[`DPCFG_ST_VALID] = state_r.cfg.interp_valid;
      status_word[`DPCFG_ST_INRESET] = LINK_DESER_IN_RESET;
      status_word[`DPCFG_ST_BW_MSB:`DPCFG_ST_BW_LSB] = state_r.cfg.bandwidth_percent;
   end

   // ************************************************************
   // read answer, chosen in the setup cycle
   // ************************************************************
   always_comb begin
      read_word = 32'h0000_0000;
      read_error = 1'b0;
      if (hit_interp) begin
         read_word[7:0] = state_r.interp_lane;
      end else if (hit_feature) begin
         read_word[7:0] = state_r.feature;
      end else if (hit_status && !PWRITE) begin
         read_word = status_word;
      end else begin
         // unmapped, misaligned, or write to read-only status
         read_error = 1'b1;
      end
   end

   // ************************************************************
   // decoded configuration, registered with the fields it follows
   // ************************************************************
   always_comb begin
      cfg_nxt.serial_lane_count = interp_lane_nxt[`DPCFG_LANE_MSB:`DPCFG_LANE_LSB];
      cfg_nxt.interpolation_select = interp_lane_nxt[`DPCFG_INTERP_MSB:`DPCFG_INTERP_LSB];
      cfg_nxt.interp_ratio = dec_ratio;
      cfg_nxt.interp_valid = dec_valid;
      cfg_nxt.inverse_sinc_enable = feature_nxt[`DPCFG_BIT_INVSINC];
      // enables without rules of their own pass straight through
      cfg_nxt.oscillator_mix_enable = feature_nxt[`DPCFG_BIT_OSCMIX];
      cfg_nxt.modulus_enable = feature_nxt[`DPCFG_BIT_MODULUS];
      cfg_nxt.sideband_select = feature_nxt[`DPCFG_BIT_SIDEBAND];
      cfg_nxt.halfband_enable = feature_nxt[`DPCFG_BIT_HALFBAND];
      cfg_nxt.datapath_bandwidth_select = feature_nxt[`DPCFG_BIT_BANDWIDTH];
      if (feature_nxt[`DPCFG_BIT_BANDWIDTH]) begin
         cfg_nxt.bandwidth_percent = `DPCFG_BW_WIDE;
      end else begin
         cfg_nxt.bandwidth_percent = `DPCFG_BW_NARROW;
      end
   end

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      state_nxt = state_r;
      case (state_r.bus_state)
         DPCFG_ST_IDLE: begin
            state_nxt.pready = 1'b0;
            state_nxt.pslverr = 1'b0;
            if (setup_phase) begin
               // answer prepared in setup so access needs no wait
               state_nxt.bus_state = DPCFG_ST_ANSWER;
               state_nxt.pready = 1'b1;
               state_nxt.prdata = read_word;
               state_nxt.pslverr = read_error;
            end
         end
         DPCFG_ST_ANSWER: begin
            if (access_done) begin
               state_nxt.bus_state = DPCFG_ST_IDLE;
               state_nxt.pready = 1'b0;
               state_nxt.pslverr = 1'b0;
               // the store itself goes through write_ok; here the answer retires
               state_nxt.prdata = 32'h0000_0000;
            end
         end
         default: begin
            // unreachable with two states; a safe way back to idle
            state_nxt.bus_state = DPCFG_ST_IDLE;
            state_nxt.pready = 1'b0;
            state_nxt.pslverr = 1'b0;
         end
      endcase

      // stores land on the commit edge; cfg moves with them
      state_nxt.interp_lane = interp_lane_nxt;
      state_nxt.feature = feature_nxt;
      state_nxt.cfg = cfg_nxt;
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_r.bus_state <= DPCFG_ST_IDLE;
         state_r.interp_lane <= {`DPCFG_LANE_RESET, `DPCFG_INTERP_RESET};
         state_r.feature <= `DPCFG_FEATURE_RESET;
         state_r.pready <= 1'b0;
         state_r.pslverr <= 1'b0;
         state_r.prdata <= 32'h0000_0000;
         state_r.cfg.serial_lane_count <= `DPCFG_LANE_RESET;
         state_r.cfg.interpolation_select <= `DPCFG_INTERP_RESET;
         state_r.cfg.interp_ratio <= `DPCFG_RATIO_NONE;
         state_r.cfg.interp_valid <= 1'b0;
         state_r.cfg.inverse_sinc_enable <= 1'b0;
         state_r.cfg.oscillator_mix_enable <= 1'b0;
         state_r.cfg.modulus_enable <= 1'b0;
         state_r.cfg.sideband_select <= 1'b0;
         state_r.cfg.halfband_enable <= 1'b0;
         state_r.cfg.datapath_bandwidth_select <= 1'b0;
         state_r.cfg.bandwidth_percent <= `DPCFG_BW_NARROW;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   // every output straight from a flip-flop of state_r
   assign PREADY = state_r.pready;
   assign PRDATA = state_r.prdata;
   assign PSLVERR = state_r.pslverr;
   assign DPCFG_CFG = state_r.cfg;

endmodule

// file: core/dpcfg_regs.svh
// Purpose: named offsets, fields, reset values and codes of the datapath config bank
// Assumes: included by bare name from the package and the design modules
// Notes: register indexes are scaled by four to form APB byte addresses
//
// Operation
// - lane count in bits 7:4, resets eight
// - interp codes 4..8 give 6/8/12/16/24x, reset 1
// - bit 7 enables inverse sinc, resets zero
// - bandwidth bit zero selects 80 percent
// - bandwidth bit one selects 90 percent
`ifndef DPCFG_REGS_SVH
`define DPCFG_REGS_SVH

// ************************************************************
// register indexes (byte address is index times four)
// ************************************************************
`define DPCFG_IDX_INTERP_LANE 10'h110
`define DPCFG_IDX_FEATURE 10'h111
`define DPCFG_IDX_STATUS 10'h1F0

// ************************************************************
// fields and reset values
// ************************************************************
`define DPCFG_LANE_MSB 7
`define DPCFG_LANE_LSB 4
`define DPCFG_INTERP_MSB 3
`define DPCFG_INTERP_LSB 0
`define DPCFG_LANE_RESET 4'h8
`define DPCFG_INTERP_RESET 4'h1
`define DPCFG_FEATURE_RESET 8'h00
`define DPCFG_BIT_INVSINC 7
`define DPCFG_BIT_OSCMIX 6
`define DPCFG_BIT_BANDWIDTH 4
`define DPCFG_BIT_MODULUS 2
`define DPCFG_BIT_SIDEBAND 1
`define DPCFG_BIT_HALFBAND 0
`define DPCFG_FEATURE_WMASK 8'hD7

// ************************************************************
// interpolation codes and ratios
// ************************************************************
`define DPCFG_INTERP_6X 4'h4
`define DPCFG_INTERP_8X 4'h5
`define DPCFG_INTERP_12X 4'h6
`define DPCFG_INTERP_16X 4'h7
`define DPCFG_INTERP_24X 4'h8
`define DPCFG_RATIO_6X 5'h06
`define DPCFG_RATIO_8X 5'h08
`define DPCFG_RATIO_12X 5'h0C
`define DPCFG_RATIO_16X 5'h10
`define DPCFG_RATIO_24X 5'h18
`define DPCFG_RATIO_NONE 5'h00
`define DPCFG_BW_NARROW 7'h50
`define DPCFG_BW_WIDE 7'h5A

// ************************************************************
// status register layout
// ************************************************************
`define DPCFG_ST_RATIO_MSB 4
`define DPCFG_ST_RATIO_LSB 0
`define DPCFG_ST_VALID 5
`define DPCFG_ST_INRESET 6
`define DPCFG_ST_BW_MSB 14
`define DPCFG_ST_BW_LSB 8

`endif

// file: core/dpcfg_pkg.sv
// Purpose: types shared by the datapath config bank
// Assumes: nothing beyond the constants header
// Notes: all module state is one packed struct
`include "dpcfg_regs.svh"

package dpcfg_pkg;

   // ************************************************************
   // decoded configuration driven to the datapath
   // ************************************************************
   typedef struct packed {
      logic [3:0] serial_lane_count;
      logic [3:0] interpolation_select;
      logic [4:0] interp_ratio;
      logic interp_valid;
      logic inverse_sinc_enable;
      logic oscillator_mix_enable;
      logic modulus_enable;
      logic sideband_select;
      logic halfband_enable;
      logic datapath_bandwidth_select;
      logic [6:0] bandwidth_percent;
   } dpcfg_cfg_t;

   typedef enum logic {
      DPCFG_ST_IDLE,
      DPCFG_ST_ANSWER
   } dpcfg_bus_state_t;

   typedef struct packed {
      dpcfg_bus_state_t bus_state;
      logic [7:0] interp_lane;
      logic [7:0] feature;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      dpcfg_cfg_t cfg;
   } dpcfg_state_t;

endpackage

// file: core/dpcfg_interp_decode.sv
// Purpose: turns the interpolation code into a ratio and a valid flag
// Assumes: purely combinational, read by the bank's next-state logic
// Notes: reserved codes give ratio zero and valid low
`timescale 1ns/1ps
`include "dpcfg_regs.svh"

module dpcfg_interp_decode (
   input wire logic [3:0] code,
   output logic [4:0] ratio,
   output logic valid
);
   import dpcfg_pkg::*;

   // ************************************************************
   // code table
   // ************************************************************
   always_comb begin
      ratio = `DPCFG_RATIO_NONE;
      valid = 1'b1;
      case (code)
         `DPCFG_INTERP_6X: ratio = `DPCFG_RATIO_6X;
         `DPCFG_INTERP_8X: ratio = `DPCFG_RATIO_8X;
         `DPCFG_INTERP_12X: ratio = `DPCFG_RATIO_12X;
         `DPCFG_INTERP_16X: ratio = `DPCFG_RATIO_16X;
         `DPCFG_INTERP_24X: ratio = `DPCFG_RATIO_24X;
         default: valid = 1'b0;
      endcase
   end

endmodule

// file: test/dpcfg_top_asserts.sv
// Purpose: port assertions for the datapath config bank
// Assumes: APB master holds its request until PREADY is seen high
// Notes: bound to every dpcfg_top instance
`timescale 1ns/1ps
// ********************
// checker
// ********************
module dpcfg_top_asserts (
   input wire logic REF_CLK,
   input wire logic RESETN,
   input wire logic [11:0] PADDR,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   input wire logic LINK_DESER_IN_RESET,
   input wire logic PREADY,
   input wire logic [31:0] PRDATA,
   input wire logic PSLVERR,
   input wire dpcfg_pkg::dpcfg_cfg_t DPCFG_CFG
);
   import dpcfg_pkg::*;
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RESETN);
   logic done;
   logic wr_lane;
   logic wr_feat;
   assign done = PSEL && PENABLE && PREADY;
   assign wr_lane = done && PWRITE && PSTRB[0] && PADDR == 12'h440;
   assign wr_feat = done && PWRITE && PSTRB[0] && PADDR == 12'h444;
   function automatic logic [4:0] rat(input logic [3:0] c);
      case (c)
         4'h4: rat = 5'h06;
         4'h5: rat = 5'h08;
         4'h6: rat = 5'h0C;
         4'h7: rat = 5'h10;
         4'h8: rat = 5'h18;
         default: rat = 5'h00;
      endcase
   endfunction
   chk_lane_store: assert property (wr_lane |=>
      DPCFG_CFG.serial_lane_count == $past(PWDATA[7:4])) else $error("lane count not stored");
   chk_interp_ratio: assert property (
      DPCFG_CFG.interp_ratio == rat(DPCFG_CFG.interpolation_select)) else $error("interp ratio wrong");
   chk_interp_valid: assert property (
      DPCFG_CFG.interp_valid == (DPCFG_CFG.interp_ratio != 5'h00)) else $error("interp valid wrong");
   chk_sinc_store: assert property (wr_feat |=>
      DPCFG_CFG.inverse_sinc_enable == $past(PWDATA[7])) else $error("inverse sinc not stored");
   chk_bw_narrow: assert property (!DPCFG_CFG.datapath_bandwidth_select |->
      DPCFG_CFG.bandwidth_percent == 7'h50) else $error("narrow bandwidth wrong");
   chk_bw_wide: assert property (wr_feat && PWDATA[4] |=>
      DPCFG_CFG.bandwidth_percent == 7'h5A) else $error("wide bandwidth wrong");
   chk_resv_zero: assert property (done && !PWRITE && PADDR == 12'h444 |->
      PRDATA[5] == 1'b0 && PRDATA[3] == 1'b0) else $error("reserved bits not zero");
   chk_answer_next: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY) else $error("answer timing wrong");
   cover property (wr_lane);
   cover property (wr_feat && PWDATA[4]);
   cover property (done && PSLVERR);
endmodule
bind dpcfg_top dpcfg_top_asserts u_chk (.REF_CLK(REF_CLK), .RESETN(RESETN), .PADDR(PADDR), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA), .PSTRB(PSTRB), .LINK_DESER_IN_RESET(LINK_DESER_IN_RESET),
   .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .DPCFG_CFG(DPCFG_CFG));

// file: test/testbench.sv
// Purpose: self-checking bench of the datapath config bank
// Assumes: zero-wait APB answers, but waits on PREADY anyway
// Notes: random data from a fixed seed plus corner values
`timescale 1ns/1ps
// ********************
// bench
// ********************
module testbench;
   import dpcfg_pkg::*;
   logic REF_CLK;
   logic RESETN;
   logic PSEL;
   logic PENABLE;
   logic PWRITE;
   logic LINK_DESER_IN_RESET;
   logic PREADY;
   logic PSLVERR;
   logic er;
   logic [11:0] PADDR;
   logic [31:0] PWDATA;
   logic [31:0] PRDATA;
   logic [31:0] rd;
   logic [3:0] PSTRB;
   logic [7:0] d;
   logic [7:0] feat;
   dpcfg_cfg_t DPCFG_CFG;
   integer seed = 59713;
   integer bad_count = 0;
   integer comparisons = 0;
   integer cycles = 0;
   integer i;
   dpcfg_top DUT (.REF_CLK(REF_CLK), .RESETN(RESETN), .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PWDATA(PWDATA), .PSTRB(PSTRB), .LINK_DESER_IN_RESET(LINK_DESER_IN_RESET),
      .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .DPCFG_CFG(DPCFG_CFG));
   initial begin
      REF_CLK = 1'b0;
      forever #10 REF_CLK = ~REF_CLK;
   end
   task print_verdict;
      $display("checks %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // generous: the whole run needs well under a thousand cycles
   always @(posedge REF_CLK) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         print_verdict();
      end
   end
   task check(input string n, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [7:0] v, input logic [3:0] s);
      @(posedge REF_CLK);
      PSEL <= 1'b1;
      PADDR <= a;
      PWRITE <= w;
      PWDATA <= {24'h000000, v};
      PSTRB <= s;
      @(posedge REF_CLK);
      PENABLE <= 1'b1;
      do @(posedge REF_CLK); while (PREADY !== 1'b1);
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   function automatic logic [4:0] ratio(input logic [3:0] c);
      ratio = (c == 4'h4) ? 5'h06 : (c == 4'h5) ? 5'h08 : (c == 4'h6) ? 5'h0C :
         (c == 4'h7) ? 5'h10 : (c == 4'h8) ? 5'h18 : 5'h00;
   endfunction
   initial begin
      {PSEL, PENABLE, PWRITE, PADDR, PWDATA, PSTRB} = '0;
      LINK_DESER_IN_RESET = 1'b0;
      RESETN = 1'b0;
      repeat (20) @(posedge REF_CLK);
      RESETN <= 1'b1;
      apb(1'b0, 12'h440, 8'h00, 4'h0);
      check("lane reg", rd, 32'h81);
      apb(1'b0, 12'h444, 8'h00, 4'h0);
      check("feature reg", rd, 32'h00);
      check("bandwidth", DPCFG_CFG.bandwidth_percent, 7'h50);
      $display("reset test done");
      LINK_DESER_IN_RESET <= 1'b1;
      for (i = 0; i < 16; i++) begin
         d = {4'($random(seed)), 4'(i)};
         apb(1'b1, 12'h440, d, 4'h1);
         apb(1'b0, 12'h440, 8'h00, 4'h0);
         check("lane reg", rd, {24'h0, d});
         check("ratio", DPCFG_CFG.interp_ratio, ratio(d[3:0]));
         check("lane count", DPCFG_CFG.serial_lane_count, d[7:4]);
         check("lane read error", er, 1'b0);
         apb(1'b0, 12'h7C0, 8'h00, 4'h0);
         check("status", rd[6:0], {1'b1, ratio(d[3:0]) != 5'h00, ratio(d[3:0])});
      end
      LINK_DESER_IN_RESET <= 1'b0;
      apb(1'b0, 12'h7C0, 8'h00, 4'h0);
      check("status idle", {rd[14:8], rd[6]}, {7'h50, 1'b0});
      $display("interpolation test done");
      for (i = 0; i < 10; i++) begin
         d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
         feat = d & 8'hD7;
         apb(1'b1, 12'h444, d, 4'h1);
         apb(1'b0, 12'h444, 8'h00, 4'h0);
         check("feature reg", rd, {24'h0, feat});
         check("inverse sinc", DPCFG_CFG.inverse_sinc_enable, d[7]);
         check("feature bits", {DPCFG_CFG.oscillator_mix_enable, DPCFG_CFG.datapath_bandwidth_select,
            DPCFG_CFG.modulus_enable, DPCFG_CFG.sideband_select, DPCFG_CFG.halfband_enable}, {d[6], d[4], d[2:0]});
         check("bandwidth", DPCFG_CFG.bandwidth_percent, d[4] ? 7'h5A : 7'h50);
      end
      $display("feature test done");
      apb(1'b1, 12'h448, 8'hFF, 4'h1);
      check("error unmapped", er, 1'b1);
      apb(1'b1, 12'h445, 8'hFF, 4'h1);
      check("error misaligned", er, 1'b1);
      apb(1'b1, 12'h7C0, 8'hFF, 4'h1);
      check("error status write", er, 1'b1);
      apb(1'b1, 12'h444, 8'hFF, 4'h0);
      apb(1'b0, 12'h444, 8'h00, 4'h0);
      check("feature kept", rd, {24'h0, feat});
      $display("error test done");
      print_verdict();
   end
endmodule
